// ---- design/tdf_formatter.sv ----
// readout word formatter with wishbone registers and serial link
// assumes synchronous inputs, one clock, chain token pulse from upstream
`timescale 1ns/100ps
`default_nettype none
`include "tdf_map.svh"
module tdf_formatter (
    // clock, reset, freeze
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // control line
    input wire logic I_CMD_LINE,
    // wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // word requests
    input wire logic I_REQ_VALID,
    input wire logic [2:0] I_REQ_KIND,
    input wire tdf_pkg::tdf_req_t I_REQ,
    output logic O_REQ_READY,
    // serial link and chain
    output logic O_SER_DATA,
    output logic O_SER_EN,
    input wire logic I_CHAIN_GO,
    output logic O_CHAIN_DONE
);
    import tdf_pkg::*;
    tdf_cmd_if cmd ();
    logic [31:0] ctrl_q;
    logic [11:0] bx_q, evt_q, loc_q, glb_q;
    logic sep_q, pend_q, token_q, arm_q, close_q;
    tdf_word_t pend_kind_q;
    tdf_req_t req_q;
    logic [31:0] sh_q;
    logic [4:0] bit_q;
    logic fire, ser_free, can_take, load, v1, v2, ok;
    tdf_word_t k1, k2, ld_kind;
    logic [31:0] ld_word;
    logic wb_hit;

    tdf_cmd_decoder u_dec (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_line(I_CMD_LINE),
        .cmd(cmd)
    );

    function automatic logic [31:0] compose(input tdf_word_t k, input tdf_req_t r,
            input logic [31:0] c, input logic [11:0] ev, input logic [11:0] bx,
            input logic [11:0] lc, input logic [11:0] gc);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`TDF_F_ID] = c[`TDF_C_OWN];
        unique case (k)
            W_GHDR, W_LHDR: begin
                w[`TDF_F_TYPE] = (k == W_GHDR) ? `TDF_T_GHDR : `TDF_T_LHDR;
                if (k == W_GHDR) w[`TDF_F_ID] = c[`TDF_C_MST];
                w[`TDF_F_EVT] = ev;
                w[`TDF_F_BX] = bx;
            end
            W_GTRL: begin
                w[`TDF_F_TYPE] = `TDF_T_GTRL;
                w[`TDF_F_ID] = c[`TDF_C_MST];
                w[`TDF_F_EVT] = ev;
                w[`TDF_F_BX] = gc + 12'h001;
            end
            W_LTRL: begin
                w[`TDF_F_TYPE] = `TDF_T_LTRL;
                w[`TDF_F_EVT] = ev;
                w[`TDF_F_BX] = lc + 12'h001;
            end
            W_ERR: begin
                w[`TDF_F_TYPE] = `TDF_T_ERR;
                w[`TDF_F_ERR] = r.flags[`TDF_F_ERR];
            end
            W_MASK0, W_MASK1: begin
                w[`TDF_F_TYPE] = `TDF_T_MASK;
                if (!c[`TDF_C_CH32]) begin
                    w[`TDF_F_M24] = r.flags[`TDF_F_M24];
                end else begin
                    w[`TDF_F_GRP] = (k == W_MASK1);
                    w[`TDF_F_M16] = (k == W_MASK1) ? r.flags[`TDF_F_HI16] : r.flags[`TDF_F_M16];
                end
            end
            W_SINGLE: begin
                w[`TDF_F_TYPE] = `TDF_T_SINGLE;
                w[`TDF_F_CHAN] = r.chan;
                w[`TDF_F_EDGE] = r.edge_t;
                w[`TDF_F_REJ] = r.rej;
                w[`TDF_F_COARSE] = r.coarse;
                w[`TDF_F_FINE] = r.fine;
            end
            W_CHARGE, W_WIDTH: begin
                w[`TDF_F_TYPE] = (k == W_CHARGE) ? `TDF_T_CHARGE : `TDF_T_WIDTH;
                w[`TDF_F_CHAN] = r.chan;
                w[`TDF_F_AUX] = r.aux;
                w[`TDF_F_RCOARSE] = r.coarse[`TDF_F_RSRC];
                w[`TDF_F_FINE] = r.fine;
            end
            W_SEP: begin
                w[`TDF_F_TYPE] = `TDF_T_MON;
                w[`TDF_F_ID] = `TDF_SUB_SEP;
                w[`TDF_F_BX] = bx;
            end
            W_STAT: begin
                w[`TDF_F_TYPE] = `TDF_T_MON;
                w[`TDF_F_ID] = `TDF_SUB_STAT;
                w[`TDF_F_OCC] = r.flags[`TDF_F_OCC];
                w[`TDF_F_FULL] = r.flags[`TDF_F_FULL];
            end
        endcase
        return w;
    endfunction

    // request to word plan: first word and optional second
    always_comb begin
        v1 = 1'b1;
        v2 = 1'b0;
        k1 = W_SINGLE;
        k2 = W_GTRL;
        unique case (I_REQ_KIND)
            `TDF_RK_BEGIN: begin
                v1 = ctrl_q[`TDF_C_MASTER] | ctrl_q[`TDF_C_LOC];
                k1 = ctrl_q[`TDF_C_MASTER] ? W_GHDR : W_LHDR;
                v2 = ctrl_q[`TDF_C_MASTER] & ctrl_q[`TDF_C_LOC];
                k2 = W_LHDR;
            end
            `TDF_RK_END: begin
                v1 = ctrl_q[`TDF_C_MASTER] | ctrl_q[`TDF_C_LOC];
                k1 = ctrl_q[`TDF_C_LOC] ? W_LTRL : W_GTRL;
                v2 = ctrl_q[`TDF_C_MASTER] & ctrl_q[`TDF_C_LOC];
                k2 = W_GTRL;
            end
            `TDF_RK_SINGLE: k1 = W_SINGLE;
            `TDF_RK_CHARGE: k1 = W_CHARGE;
            `TDF_RK_WIDTH: k1 = W_WIDTH;
            `TDF_RK_ERR: k1 = W_ERR;
            `TDF_RK_MASK: begin
                k1 = W_MASK0;
                v2 = ctrl_q[`TDF_C_CH32];
                k2 = W_MASK1;
            end
            `TDF_RK_STAT: k1 = W_STAT;
        endcase
    end

    // priority: pending second word, new request, separator
    assign ser_free = !O_SER_EN || bit_q == 5'h00;
    assign ok = ctrl_q[`TDF_C_FIRST] | token_q;
    assign fire = I_CE && I_REQ_VALID && O_REQ_READY;
    assign can_take = ok && !pend_q && !sep_q && !arm_q && ser_free;
    always_comb begin
        load = 1'b0;
        ld_kind = k1;
        ld_word = compose(k1, I_REQ, ctrl_q, evt_q, bx_q, loc_q, glb_q);
        if (I_CE && pend_q && ser_free) begin
            load = 1'b1;
            ld_kind = pend_kind_q;
            ld_word = compose(pend_kind_q, req_q, ctrl_q, evt_q, bx_q, loc_q, glb_q);
        end else if (fire) begin
            load = v1;
        end else if (I_CE && sep_q && ser_free && ok) begin
            load = 1'b1;
            ld_kind = W_SEP;
            ld_word = compose(W_SEP, req_q, ctrl_q, evt_q, bx_q, loc_q, glb_q);
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_REQ_READY <= 1'b0;
        end else if (I_CE) begin
            O_REQ_READY <= can_take && !load && !fire && !cmd.glob_rst;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || (I_CE && cmd.glob_rst)) begin
            pend_q <= 1'b0;
            pend_kind_q <= W_GTRL;
            req_q <= '0;
        end else if (fire) begin
            pend_q <= v2;
            pend_kind_q <= k2;
            req_q <= I_REQ;
        end else if (load && pend_q) begin
            pend_q <= 1'b0;
        end
    end

    // separator request; a new bunch or event reset command wins over its clear
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sep_q <= 1'b0;
        end else if (I_CE) begin
            if ((cmd.bunch_rst || cmd.evt_rst) && ctrl_q[`TDF_C_SEP]) begin
                sep_q <= 1'b1;
            end else if (cmd.glob_rst || (load && ld_kind == W_SEP)) begin
                sep_q <= 1'b0;
            end
        end
    end

    // bunch runs every enabled cycle; event counts triggers
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            bx_q <= 12'h000;
            evt_q <= 12'h000;
        end else if (I_CE) begin
            bx_q <= (cmd.bunch_rst || cmd.glob_rst) ? 12'h000 : bx_q + 12'h001;
            if (cmd.evt_rst || cmd.glob_rst) begin
                evt_q <= 12'h000;
            end else if (cmd.trig) begin
                evt_q <= evt_q + 12'h001;
            end
        end
    end

    // word counts include the header that restarted them
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || (I_CE && cmd.glob_rst)) begin
            loc_q <= 12'h000;
            glb_q <= 12'h000;
        end else if (load) begin
            loc_q <= (ld_kind == W_LHDR) ? 12'h001 : loc_q + 12'h001;
            glb_q <= (ld_kind == W_GHDR) ? 12'h001 : glb_q + 12'h001;
        end
    end

    // chain token: upstream done pulse wins over our own release
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            token_q <= 1'b0;
            arm_q <= 1'b0;
            O_CHAIN_DONE <= 1'b0;
        end else if (I_CE) begin
            O_CHAIN_DONE <= arm_q && !pend_q && ser_free && !load;
            if (I_CHAIN_GO) begin
                token_q <= 1'b1;
            end else if (cmd.glob_rst || (arm_q && !pend_q && ser_free && !load)) begin
                token_q <= 1'b0;
            end
            if (fire && I_REQ_KIND == `TDF_RK_END) begin
                arm_q <= 1'b1;
            end else if (cmd.glob_rst || (!pend_q && ser_free && !load)) begin
                arm_q <= 1'b0;
            end
        end
    end

    // msb first, one bit per clock, nrz; back-to-back words stay framed
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sh_q <= 32'h0000_0000;
            bit_q <= 5'h00;
            O_SER_DATA <= 1'b0;
            O_SER_EN <= 1'b0;
        end else if (I_CE) begin
            if (load) begin
                sh_q <= ld_word;
                bit_q <= `TDF_BIT_LAST;
                O_SER_DATA <= ld_word[31];
                O_SER_EN <= 1'b1;
            end else if (bit_q != 5'h00) begin
                sh_q <= {sh_q[30:0], 1'b0};
                bit_q <= bit_q - 5'h01;
                O_SER_DATA <= sh_q[30];
            end else begin
                O_SER_EN <= 1'b0;
                O_SER_DATA <= 1'b0;
            end
        end
    end

    // wishbone: ack one cycle after the strobe, dropped the next
    assign wb_hit = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0000_0000;
            ctrl_q <= `TDF_CTRL_RST;
        end else if (I_CE) begin
            O_WB_ACK <= wb_hit;
            O_WB_DAT <= 32'h0000_0000;
            if (wb_hit && !I_WB_WE) begin
                unique case (I_WB_ADR)
                    `TDF_A_CTRL: O_WB_DAT <= ctrl_q;
                    `TDF_A_STAT: begin
                        O_WB_DAT[`TDF_S_BX] <= bx_q;
                        O_WB_DAT[`TDF_S_EVT] <= evt_q;
                        O_WB_DAT[`TDF_S_READY] <= O_REQ_READY;
                        O_WB_DAT[`TDF_S_BUSY] <= O_SER_EN;
                        O_WB_DAT[`TDF_S_TOKEN] <= token_q;
                        O_WB_DAT[`TDF_S_CLOSE] <= close_q;
                    end
                    `TDF_A_CNT: O_WB_DAT <= {8'h00, glb_q, loc_q};
                    default: O_WB_DAT <= 32'h0000_0000;
                endcase
            end
            if (wb_hit && I_WB_WE && I_WB_ADR == `TDF_A_CTRL) begin
                for (int b = 0; b < 4; b++) begin
                    if (I_WB_SEL[b]) ctrl_q[b*8 +: 8] <= I_WB_DAT[b*8 +: 8];
                end
            end
        end
    end

    // sticky spacing violation, write one to clear, a new one wins
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            close_q <= 1'b0;
        end else if (I_CE) begin
            if (cmd.too_close) begin
                close_q <= 1'b1;
            end else if (wb_hit && I_WB_WE && I_WB_ADR == `TDF_A_STAT && I_WB_SEL[3]
                    && I_WB_DAT[`TDF_S_CLOSE]) begin
                close_q <= 1'b0;
            end
        end
    end

    sequence s_mask32;
        load && ld_kind == W_MASK1 && ctrl_q[`TDF_C_CH32];
    endsequence

    a_hdr_fields: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (load && ld_kind == W_GHDR) |=> sh_q[`TDF_F_TYPE] == `TDF_T_GHDR
            && sh_q[`TDF_F_ID] == $past(ctrl_q[`TDF_C_MST]) && sh_q[`TDF_F_EVT] == $past(evt_q))
        else $error("global header fields wrong");
    a_ltrl_count: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (load && ld_kind == W_LTRL) |=> sh_q[`TDF_F_BX] == loc_q && sh_q[`TDF_F_TYPE] == `TDF_T_LTRL)
        else $error("local trailer count wrong");
    a_err_reserved: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (load && ld_kind == W_ERR) |=> sh_q[`TDF_F_ERSV] == 17'h00000 && sh_q[`TDF_F_TYPE] == `TDF_T_ERR)
        else $error("error word reserved bits set");
    a_mask_group: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        s_mask32 |=> sh_q[`TDF_F_GRP] && sh_q[`TDF_F_GZERO] == 7'h00)
        else $error("upper mask group malformed");
    a_single_chan: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (fire && I_REQ_KIND == `TDF_RK_SINGLE) |=> sh_q[`TDF_F_CHAN] == $past(I_REQ.chan)
            && sh_q[`TDF_F_TYPE] == `TDF_T_SINGLE)
        else $error("single word channel wrong");
    a_sep_word: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (load && ld_kind == W_SEP) |=> sh_q[`TDF_F_TYPE] == `TDF_T_MON && sh_q[`TDF_F_ID] == `TDF_SUB_SEP)
        else $error("separator word wrong");
    a_ser_frame: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (load && I_CE) ##1 I_CE [*8] |-> O_SER_EN)
        else $error("serial frame ended early");
    a_chain_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (!ctrl_q[`TDF_C_FIRST] && !token_q) |-> !fire)
        else $error("request taken without chain token");
endmodule
`default_nettype wire

// ---- design/tdf_map.svh ----
// constants of the readout word formatter
// assumes inclusion by bare name from design files
`ifndef TDF_MAP_SVH
`define TDF_MAP_SVH
`define TDF_T_GHDR 4'h9
`define TDF_T_LHDR 4'hA
`define TDF_T_GTRL 4'hB
`define TDF_T_LTRL 4'hC
`define TDF_T_ERR 4'h6
`define TDF_T_MASK 4'h2
`define TDF_T_SINGLE 4'h3
`define TDF_T_CHARGE 4'h4
`define TDF_T_WIDTH 4'h5
`define TDF_T_MON 4'h7
`define TDF_SUB_SEP 4'h0
`define TDF_SUB_STAT 4'h1
`define TDF_F_TYPE 31:28
`define TDF_F_ID 27:24
`define TDF_F_EVT 23:12
`define TDF_F_BX 11:0
`define TDF_F_ERR 6:0
`define TDF_F_ERSV 23:7
`define TDF_F_M24 23:0
`define TDF_F_GRP 23
`define TDF_F_GZERO 22:16
`define TDF_F_M16 15:0
`define TDF_F_HI16 31:16
`define TDF_F_CHAN 23:19
`define TDF_F_EDGE 18
`define TDF_F_REJ 17
`define TDF_F_COARSE 16:5
`define TDF_F_FINE 4:0
`define TDF_F_AUX 18:11
`define TDF_F_RCOARSE 10:5
`define TDF_F_RSRC 5:0
`define TDF_F_OCC 7:0
`define TDF_F_FULL 8
`define TDF_CMD_TRIG 2'h0
`define TDF_CMD_BRST 2'h2
`define TDF_CMD_ERST 2'h3
`define TDF_CMD_GRST 2'h1
`define TDF_CMD_GAP_NS 75
`define TDF_CLK_NS 4
`define TDF_GAP_CYC ((`TDF_CMD_GAP_NS + `TDF_CLK_NS - 1) / `TDF_CLK_NS)
`define TDF_RK_BEGIN 3'h0
`define TDF_RK_END 3'h1
`define TDF_RK_SINGLE 3'h2
`define TDF_RK_CHARGE 3'h3
`define TDF_RK_WIDTH 3'h4
`define TDF_RK_ERR 3'h5
`define TDF_RK_MASK 3'h6
`define TDF_RK_STAT 3'h7
`define TDF_A_CTRL 8'h00
`define TDF_A_STAT 8'h04
`define TDF_A_CNT 8'h08
`define TDF_CTRL_RST 32'h0000_0000
`define TDF_C_OWN 3:0
`define TDF_C_MST 7:4
`define TDF_C_CH32 8
`define TDF_C_LOC 9
`define TDF_C_FIRST 10
`define TDF_C_SEP 11
`define TDF_C_MASTER 12
`define TDF_S_BX 11:0
`define TDF_S_EVT 23:12
`define TDF_S_READY 24
`define TDF_S_BUSY 25
`define TDF_S_TOKEN 26
`define TDF_S_CLOSE 27
`define TDF_BIT_LAST 5'h1F
`endif

// ---- design/tdf_pkg.sv ----
// types shared by the formatter and the command decoder
// assumes tdf_map.svh for numeric constants
package tdf_pkg;
    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_BIT1 = 3'b010,
        D_BIT2 = 3'b100
    } tdf_dec_state_t;
    typedef enum logic [3:0] {
        W_GHDR, W_LHDR, W_GTRL, W_LTRL, W_ERR, W_MASK0, W_MASK1,
        W_SINGLE, W_CHARGE, W_WIDTH, W_SEP, W_STAT
    } tdf_word_t;
    typedef struct packed {
        logic [4:0] chan;
        logic edge_t;
        logic rej;
        logic [11:0] coarse;
        logic [4:0] fine;
        logic [7:0] aux;
        logic [31:0] flags;
    } tdf_req_t;
endpackage

// ---- design/tdf_cmd_if.sv ----
// decoded command pulses from decoder to formatter
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface tdf_cmd_if;
    logic trig;
    logic bunch_rst;
    logic evt_rst;
    logic glob_rst;
    logic too_close;
    modport dec (output trig, bunch_rst, evt_rst, glob_rst, too_close);
    modport fmt (input trig, bunch_rst, evt_rst, glob_rst, too_close);
endinterface
`default_nettype wire

// ---- design/tdf_cmd_decoder.sv ----
// three-cycle control line decoder
// assumes the line is synchronous to the clock
`timescale 1ns/100ps
`default_nettype none
`include "tdf_map.svh"
module tdf_cmd_decoder (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_line,
    tdf_cmd_if.dec cmd
);
    import tdf_pkg::*;
    tdf_dec_state_t state_q;
    logic b1_q;
    logic [4:0] gap_q;
    logic [1:0] code;
    logic start;

    assign code = {b1_q, i_line};
    assign start = (state_q == D_IDLE) && i_line;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= D_IDLE;
        end else if (i_ce) begin
            unique case (state_q)
                D_IDLE: if (i_line) state_q <= D_BIT1;
                D_BIT1: state_q <= D_BIT2;
                D_BIT2: state_q <= D_IDLE;
                default: state_q <= D_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            b1_q <= 1'b0;
        end else if (i_ce && state_q == D_BIT1) begin
            b1_q <= i_line;
        end
    end

    // pulses are held while frozen; the formatter is frozen too
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cmd.trig <= 1'b0;
            cmd.bunch_rst <= 1'b0;
            cmd.evt_rst <= 1'b0;
            cmd.glob_rst <= 1'b0;
        end else if (i_ce) begin
            cmd.trig <= state_q == D_BIT2 && code == `TDF_CMD_TRIG;
            cmd.bunch_rst <= state_q == D_BIT2 && code == `TDF_CMD_BRST;
            cmd.evt_rst <= state_q == D_BIT2 && code == `TDF_CMD_ERST;
            cmd.glob_rst <= state_q == D_BIT2 && code == `TDF_CMD_GRST;
        end
    end

    // spacing check only reports; decoding proceeds regardless
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gap_q <= 5'h00;
            cmd.too_close <= 1'b0;
        end else if (i_ce) begin
            cmd.too_close <= start && gap_q != 5'h00;
            if (start) begin
                gap_q <= 5'(`TDF_GAP_CYC - 1);
            end else if (gap_q != 5'h00) begin
                gap_q <= gap_q - 5'h01;
            end
        end
    end

    sequence s_trig_code;
        (i_ce && state_q == D_IDLE && i_line) ##1 (i_ce && !i_line) ##1 (i_ce && !i_line);
    endsequence
    sequence s_evt_code;
        (i_ce && state_q == D_IDLE && i_line) ##1 (i_ce && i_line) ##1 (i_ce && i_line);
    endsequence

    a_trig_decode: assert property (@(posedge i_clk) disable iff (i_rst)
        s_trig_code |=> cmd.trig && !cmd.evt_rst)
        else $error("trigger code not decoded");
    a_evt_decode: assert property (@(posedge i_clk) disable iff (i_rst)
        s_evt_code |=> cmd.evt_rst && !cmd.bunch_rst)
        else $error("event reset code not decoded");
    a_tail_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && state_q == D_IDLE && i_line) ##1 i_ce |=> state_q == D_BIT2)
        else $error("command tail restarted decoding");
endmodule
`default_nettype wire

// ---- sim/tdf_link_model.sv ----
// serial link receiver standing in for the readout driver
// assumes one plain bit per clock while enable is high
`timescale 1ns/100ps
`default_nettype none
module tdf_link_model (
    // link side
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ser_data,
    input wire logic i_ser_en,
    // captured words
    output logic [31:0] o_word,
    output var int o_count
);
    logic [31:0] sh_q;
    logic [4:0] n_q;
    // msb first, no decoding of the bit stream
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sh_q <= 32'h0;
            n_q <= 5'h0;
            o_word <= 32'h0;
            o_count <= 0;
        end else if (i_ser_en) begin
            sh_q <= {sh_q[30:0], i_ser_data};
            n_q <= n_q + 5'h1;
            if (n_q == 5'h1F) begin
                o_word <= {sh_q[30:0], i_ser_data};
                o_count <= o_count + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the readout word formatter
// assumes the link model captures every serial word
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tdf_pkg::*;
    logic clk, rst, line, cyc, we, rv, ack, rdy, sd, se, go, done;
    logic [7:0] adr;
    logic [2:0] kd;
    logic [31:0] wd, rd, w, word;
    tdf_req_t rq;
    int n_fail = 0;
    int compares = 0;
    int nw = 0;
    int cnt;
    int n_done = 0;
    tdf_formatter u_tdf_formatter (.I_REF_CLK(clk), .I_RST(rst), .I_CE(1'h1), .I_CMD_LINE(line),
        .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wd),
        .O_WB_DAT(rd), .O_WB_ACK(ack), .I_REQ_VALID(rv), .I_REQ_KIND(kd), .I_REQ(rq), .O_REQ_READY(rdy),
        .O_SER_DATA(sd), .O_SER_EN(se), .I_CHAIN_GO(go), .O_CHAIN_DONE(done));
    tdf_link_model u_tdf_link_model (.i_clk(clk), .i_rst(rst), .i_ser_data(sd), .i_ser_en(se),
        .o_word(word), .o_count(cnt));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // done is a one-cycle pulse, so count it rather than poll it
    always @(posedge clk) begin
        if (done === 1'h1) n_done++;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic hung;
        n_fail++;
        $display("[ERR] %0t wait timed out", $time);
        conclude;
    endtask
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc <= 1'h1;
        we <= wr;
        adr <= a;
        wd <= d;
        for (i = 0; i < 9; i++) begin
            @(posedge clk);
            if (ack === 1'h1) break;
        end
        if (i == 9) hung;
        w = rd;
        cyc <= 1'h0;
        @(posedge clk);
    endtask
    task automatic send(input logic [2:0] k);
        int i;
        rv <= 1'h1;
        kd <= k;
        for (i = 0; i < 500; i++) begin
            @(posedge clk);
            if (rdy === 1'h1) break;
        end
        if (i == 500) hung;
        rv <= 1'h0;
    endtask
    task automatic getw(input logic [31:0] e, input logic [31:0] m);
        int i;
        for (i = 0; i < 300 && cnt == nw; i++) @(posedge clk);
        if (cnt == nw) hung;
        nw++;
        chk(word & m, e & m);
    endtask
    // spacing kept well above the minimum trigger gap
    task automatic cmd(input logic b1, input logic b2);
        line <= 1'h1;
        @(posedge clk) line <= b1;
        @(posedge clk) line <= b2;
        @(posedge clk) line <= 1'h0;
        repeat (24) @(posedge clk);
    endtask
    task automatic t_regs;
        wb(1'h1, 8'h00, 32'h0000_1635);
        wb(1'h0, 8'h00, 32'h0);
        chk(w, 32'h0000_1635);
        wb(1'h1, 8'h40, 32'hFFFF_FFFF);
        wb(1'h0, 8'h40, 32'h0);
        chk(w, 32'h0);
    endtask
    task automatic t_cmds;
        cmd(1'h0, 1'h0);
        cmd(1'h0, 1'h0);
        wb(1'h0, 8'h04, 32'h0);
        chk(w & 32'h08FF_F000, 32'h0000_2000);
        cmd(1'h1, 1'h1);
        wb(1'h0, 8'h04, 32'h0);
        chk(w & 32'h00FF_F000, 32'h0);
        cmd(1'h0, 1'h0);
        cmd(1'h0, 1'h1);
        wb(1'h0, 8'h04, 32'h0);
        chk(w & 32'h00FF_F000, 32'h0);
        cmd(1'h1, 1'h0);
        wb(1'h0, 8'h04, 32'h0);
        // bunch count restarts one edge after the code ends
        chk(w & 32'h0000_0FFF, 32'h0000_0017);
        cmd(1'h0, 1'h0);
    endtask
    // second bunch reset starts three cycles after the first
    task automatic t_close;
        line <= 1'h1;
        @(posedge clk) line <= 1'h1;
        @(posedge clk) line <= 1'h0;
        @(posedge clk);
        cmd(1'h1, 1'h0);
        wb(1'h0, 8'h04, 32'h0);
        chk(w & 32'h0800_0000, 32'h0800_0000);
        wb(1'h1, 8'h04, 32'h0800_0000);
        wb(1'h0, 8'h04, 32'h0);
        chk(w & 32'h0800_0000, 32'h0);
        wb(1'h1, 8'h00, 32'h0000_1E35);
        cmd(1'h1, 1'h0);
        getw(32'h7000_0000, 32'hFFFF_FFFF);
        wb(1'h1, 8'h00, 32'h0000_1635);
    endtask
    task automatic t_event;
        send(3'h0);
        getw({4'h9, 4'h3, 12'h001, 12'h0}, 32'hFFFF_F000);
        getw({4'hA, 4'h5, 12'h001, 12'h0}, 32'hFFFF_F000);
        send(3'h1);
        getw({4'hC, 4'h5, 12'h001, 12'h002}, 32'hFFFF_FFFF);
        getw({4'hB, 4'h3, 12'h001, 12'h004}, 32'hFFFF_FFFF);
    endtask
    task automatic t_words;
        logic [31:0] e [2:7];
        e[2] = {4'h3, 4'h5, 5'h0A, 1'h1, 1'h0, 12'hABC, 5'h15};
        e[3] = {4'h4, 4'h5, 5'h0A, 8'h5A, 6'h3C, 5'h15};
        e[4] = {4'h5, 4'h5, 5'h0A, 8'h5A, 6'h3C, 5'h15};
        e[5] = {4'h6, 4'h5, 17'h0, 7'h7F};
        e[6] = {4'h2, 4'h5, 24'hFFFF7F};
        e[7] = {4'h7, 4'h1, 15'h0, 9'h17F};
        for (int k = 2; k < 8; k++) begin
            send(k[2:0]);
            getw(e[k], 32'hFFFF_FFFF);
        end
        wb(1'h1, 8'h00, 32'h0000_1735);
        send(3'h6);
        getw({4'h2, 4'h5, 1'h0, 7'h0, 16'hFF7F}, 32'hFFFF_FFFF);
        getw({4'h2, 4'h5, 1'h1, 7'h0, 16'hFFFF}, 32'hFFFF_FFFF);
    endtask
    // not first in chain: wait for the upstream turn, hand it on at end
    task automatic t_chain;
        wb(1'h1, 8'h00, 32'h0000_0035);
        repeat (2) @(posedge clk);
        chk({31'h0, rdy}, 32'h0);
        go <= 1'h1;
        @(posedge clk) go <= 1'h0;
        send(3'h1);
        repeat (4) @(posedge clk);
        chk({31'h0, rdy}, 32'h0);
        chk(32'(n_done), 32'h2);
    endtask
    initial begin
        rst = 1'h1;
        line = 1'h0;
        cyc = 1'h0;
        we = 1'h0;
        rv = 1'h0;
        go = 1'h0;
        kd = 3'h0;
        adr = 8'h00;
        wd = 32'h0;
        rq = '{5'h0A, 1'h1, 1'h0, 12'hABC, 5'h15, 8'h5A, 32'hFFFF_FF7F};
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs;
        t_cmds;
        t_close;
        t_event;
        t_words;
        t_chain;
        conclude;
    end
endmodule
`default_nettype wire
